// ---- hw/csr_pkg.sv ----
/*
  Constants for the configuration tail, startup and readback block.
  Assumes a 10 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package csr_pkg;
  // ==========================================================
  // Clocking.
  localparam int SYS_CLK_HZ   = 10_000_000;
  localparam int CCLK_FAST_HZ = 6_000_000;
  localparam int CCLK_SLOW_HZ = 1_000_000;
  localparam int FAST_RAW     = SYS_CLK_HZ / CCLK_FAST_HZ;
  localparam int SLOW_RAW     = SYS_CLK_HZ / CCLK_SLOW_HZ;
  localparam int CCLK_FAST_DIV = (FAST_RAW < 1) ? 1 : FAST_RAW;
  localparam int CCLK_SLOW_DIV = (SLOW_RAW < 1) ? 1 : SLOW_RAW;
  // ==========================================================
  // Frame layout and checks.
  localparam int FRAME_DATA_BITS = 16;
  localparam int CHECK_BITS      = 4;
  localparam int FRAME_BITS      = FRAME_DATA_BITS + CHECK_BITS;
  localparam logic [3:0]  FIXED_TRAILER = 4'h6;
  localparam logic [15:0] CRC_POLY      = 16'h8005;
  // ==========================================================
  // Register map, byte addresses.
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_LEN  = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Control field positions.
  localparam int CB_FAST = 0;
  localparam int CB_CRC  = 1;
  localparam int CB_UCLK = 2;
  localparam int CB_SYNC = 3;
  localparam int CB_DONE = 4;
  localparam int CB_OE   = 6;
  localparam int CB_GSR  = 8;
  localparam int CB_RBU  = 10;
  localparam int CB_CAP  = 11;
  localparam int CB_ABRT = 12;
  localparam int CB_RBI  = 13;
  localparam int CB_STRT = 15;
  localparam logic [15:0] CTRL_RST = 16'h0240;
  localparam logic [23:0] LEN_RST  = 24'h000000;
  // ==========================================================
  // Synchroniser lanes.
  localparam int SI_DONE = 0;
  localparam int SI_UCLK = 1;
  localparam int SI_RBCK = 2;
  localparam int SI_TRIG = 3;
  localparam int SI_DIN  = 4;
  localparam int SYNC_N  = 5;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01, ST_LOAD = 5'h02, ST_STUP = 5'h04,
    ST_RUN  = 5'h08, ST_ERR  = 5'h10
  } csr_state_t;
endpackage

// ---- hw/csr_top.sv ----
/*
  FIFO and top level of the configuration tail, startup sequencer and
  readback controller. Assumes an AXI4-Lite master on i_sys_clk and
  pins from outside that domain, each synchronised before use except i_cap_state, which is sampled directly.
*/
// The address map and register access over AXI4-Lite were left to the implementer.
// Function
// - cclk rate fast or slow selectable
// - done pin driven open-drain, released high
// - CRC partial check at each frame end
// - without CRC, frame ends in 0110
// - startup clock is cclk or user clock
// - no sync: startup on length count met
// - sync: wait for done pin high
// - startup drives done, outputs, set/reset
// - steps one to four are cclk edges
// - user steps count user edges after C1
// - done-input steps follow done pin high
// - done event step programmable per mode
// - outputs and set/reset step programmable
// - readback clock is cclk or user clock; the code takes the separate i_rb_clk pin, not i_user_clk
// - trigger captures block outputs for readback
// - trigger falling edge aborts readback
`timescale 1ns/100ps
// ============================================================
// Small FIFO between capture and the readback shifter.
module csr_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_flush,
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic      [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wp;
    logic [AW:0]                 rp;
  } csr_fifo_st_t;
  csr_fifo_st_t q;
  csr_fifo_st_t n;
  // Extra pointer bit tells full from empty.
  assign o_ready = !((q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]));
  assign o_valid = (q.wp != q.rp);
  assign o_data  = q.mem[q.rp[AW-1:0]];
  // Pointer and storage update.
  always_comb begin
    n = q;
    if (i_flush) begin
      n.wp = '0;
      n.rp = '0;
    end else begin
      if (i_valid && o_ready) begin
        n.mem[q.wp[AW-1:0]] = i_data;
        n.wp = q.wp + 1'b1;
      end
      if (o_valid && i_ready) begin
        n.rp = q.rp + 1'b1;
      end
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
endmodule
// ============================================================
// Top level.
module csr_top
  import csr_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  input  wire logic [3:0]  i_s_axi_awaddr,
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  output logic [1:0]       o_s_axi_bresp,
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  input  wire logic [3:0]  i_s_axi_araddr,
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready,
  output logic [31:0]      o_s_axi_rdata,
  output logic [1:0]       o_s_axi_rresp,
  output logic             o_cclk,
  input  wire logic        i_cfg_din,
  input  wire logic        i_done_pin,
  output logic             o_done_o,
  output logic             o_done_oe,
  input  wire logic        i_user_clk,
  input  wire logic        i_rb_clk,
  input  wire logic        i_rb_trig,
  input  wire logic [31:0] i_cap_state,
  output logic             o_outputs_en,
  output logic             o_gsr,
  output logic             o_cfg_error,
  output logic             o_rb_dout,
  output logic             o_rb_busy
);
  typedef struct packed {
    csr_state_t        st;
    logic [15:0]       ctrl;
    logic [23:0]       len;
    logic              aw_held;
    logic              w_held;
    logic [3:0]        awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [SYNC_N-1:0] s1;
    logic [SYNC_N-1:0] s2;
    logic [SYNC_N-1:0] s3;
    logic [3:0]        cdiv;
    logic              tick;
    logic [23:0]       bit_cnt;
    logic [7:0]        fpos;
    logic [3:0]        chk;
    logic [15:0]       crc;
    logic [2:0]        c_cnt;
    logic [2:0]        u_cnt;
    logic              di_seen;
    logic [1:0]        di_cnt;
    logic              done_rel;
    logic              oe;
    logic              gsr;
    logic              err;
    logic              rb_busy;
    logic [31:0]       rb_sh;
    logic [4:0]        rb_n;
    logic              rb_dout;
    logic              cap_lost;
  } csr_st_t;
  csr_st_t q;
  csr_st_t n;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic fifo_flush;
  logic [31:0] fifo_out_data;
  logic sclk_edge;
  logic rb_edge;
  logic trig_rise;
  logic trig_fall;
  logic frame_end;
  logic [3:0] chk_got;
  logic [3:0] chk_want;
  logic ctl_user;
  logic ctl_sync;
  // ==========================================================
  // Helpers.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction
  // Whether a startup event programmed to sel has been reached.
  function automatic logic ev_hit(input logic is_done, input logic [1:0] sel,
                                  input logic usr, input logic syn,
                                  input logic [2:0] c, input logic [2:0] u,
                                  input logic di, input logic [1:0] dn);
    logic r;
    r = 1'b0;
    case ({usr, syn})
      2'b00: r = is_done ? (c >= {1'b0, sel} + 3'h1)
                         : (c >= ((sel == 2'h3) ? 3'h4 : {1'b0, sel} + 3'h2));
      2'b01: begin
        if (is_done) begin
          r = (c >= ((sel == 2'h3) ? 3'h3 : {1'b0, sel} + 3'h1));
        end else begin
          case (sel)
            2'h0:    r = (c >= 3'h2);
            2'h1:    r = (c >= 3'h3);
            2'h2:    r = di;
            default: r = di && (dn >= 2'h1);
          endcase
        end
      end
      2'b10: r = is_done ? ((sel == 2'h0) ? (c >= 3'h1) : (u >= {1'b0, sel} + 3'h1))
                         : (u >= ((sel == 2'h3) ? 3'h4 : {1'b0, sel} + 3'h2));
      default: begin
        if (is_done) begin
          r = (sel == 2'h0) ? (c >= 3'h1) : (u >= 3'h2);
        end else begin
          case (sel)
            2'h0:    r = (u >= 3'h2);
            2'h1:    r = di;
            2'h2:    r = di && (dn >= 2'h1);
            default: r = di && (dn >= 2'h2);
          endcase
        end
      end
    endcase
    return r;
  endfunction
  // ==========================================================
  // Combinational views of the state.
  assign ctl_user  = q.ctrl[CB_UCLK];
  assign ctl_sync  = q.ctrl[CB_SYNC];
  assign sclk_edge = ctl_user ? (q.s2[SI_UCLK] && !q.s3[SI_UCLK]) : q.tick;
  assign rb_edge   = q.ctrl[CB_RBU] ? (q.s2[SI_RBCK] && !q.s3[SI_RBCK])
                                    : q.tick;
  assign trig_rise = q.s2[SI_TRIG] && !q.s3[SI_TRIG];
  assign trig_fall = !q.s2[SI_TRIG] && q.s3[SI_TRIG];
  assign frame_end = (q.fpos == 8'(FRAME_BITS - 1));
  assign chk_got   = {q.chk[2:0], q.s2[SI_DIN]};
  assign chk_want  = q.ctrl[CB_CRC] ? q.crc[3:0] : FIXED_TRAILER;
  // Capture only in user mode with the readback primitive present.
  assign fifo_in_valid  = (q.st == ST_RUN) && trig_rise && q.ctrl[CB_CAP]
                          && q.ctrl[CB_RBI];
  assign fifo_out_ready = !q.rb_busy && (q.st == ST_RUN);
  assign fifo_flush     = trig_fall && q.ctrl[CB_ABRT];
  // Bus handshakes: one write and one read in flight.
  assign o_s_axi_awready = !q.aw_held && !q.bvalid;
  assign o_s_axi_wready  = !q.w_held && !q.bvalid;
  assign o_s_axi_arready = !q.rvalid;
  assign o_s_axi_bvalid  = q.bvalid;
  assign o_s_axi_bresp   = q.bresp;
  assign o_s_axi_rvalid  = q.rvalid;
  assign o_s_axi_rdata   = q.rdata;
  assign o_s_axi_rresp   = q.rresp;
  // Done pin only ever pulls low; the pull-up makes the high.
  assign o_done_o     = 1'b0;
  assign o_done_oe    = !q.done_rel;
  assign o_cclk       = q.tick;
  assign o_outputs_en = q.oe;
  assign o_gsr        = q.gsr;
  assign o_cfg_error  = q.err;
  assign o_rb_dout    = q.rb_dout;
  assign o_rb_busy    = q.rb_busy;
  csr_fifo #(.WIDTH(32), .DEPTH(4)) u_fifo (
    .i_clk   (i_sys_clk),
    .i_rst   (i_rst),
    .i_flush (fifo_flush),
    .i_valid (fifo_in_valid),
    .o_ready (fifo_in_ready),
    .i_data  (i_cap_state),
    .o_valid (fifo_out_valid),
    .i_ready (fifo_out_ready),
    .o_data  (fifo_out_data)
  );
  // ==========================================================
  // Next-state logic.
  always_comb begin
    n = q;
    // Two flops per pin, a third only for edge detection.
    n.s1 = {i_cfg_din, i_rb_trig, i_rb_clk, i_user_clk, i_done_pin};
    n.s2 = q.s1;
    n.s3 = q.s2;
    // Configuration clock divider.
    if (q.cdiv == 4'h0) begin
      n.cdiv = q.ctrl[CB_FAST] ? 4'(CCLK_FAST_DIV - 1) : 4'(CCLK_SLOW_DIV - 1);
      n.tick = 1'b1;
    end else begin
      n.cdiv = q.cdiv - 4'h1;
      n.tick = 1'b0;
    end
    // Register bus, write side.
    if (i_s_axi_awvalid && o_s_axi_awready) begin
      n.aw_held = 1'b1;
      n.awaddr  = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && o_s_axi_wready) begin
      n.w_held = 1'b1;
      n.wdata  = i_s_axi_wdata;
      n.wstrb  = i_s_axi_wstrb;
    end
    if (q.bvalid && i_s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (q.aw_held && q.w_held) begin
      n.aw_held = 1'b0;
      n.w_held  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = RESP_OKAY;
      case (q.awaddr)
        ADDR_CTRL: begin
          n.ctrl = 16'(merge({16'h0000, q.ctrl}, q.wdata, q.wstrb));
          n.ctrl[CB_STRT] = 1'b0;
          // A start restarts loading from any state.
          if (q.wstrb[1] && q.wdata[CB_STRT]) begin
            n.st       = ST_LOAD;
            n.bit_cnt  = '0;
            n.fpos     = '0;
            n.chk      = '0;
            n.crc      = '0;
            n.c_cnt    = '0;
            n.u_cnt    = '0;
            n.di_seen  = 1'b0;
            n.di_cnt   = '0;
            n.done_rel = 1'b0;
            n.oe       = 1'b0;
            n.gsr      = 1'b1;
            n.err      = 1'b0;
            n.cap_lost = 1'b0;
          end
        end
        ADDR_LEN:  n.len = 24'(merge({8'h00, q.len}, q.wdata, q.wstrb));
        ADDR_STAT: n.bresp = RESP_OKAY;
        default:   n.bresp = RESP_SLVERR;
      endcase
    end
    // Register bus, read side.
    if (q.rvalid && i_s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (i_s_axi_arvalid && o_s_axi_arready) begin
      n.rvalid = 1'b1;
      n.rresp  = RESP_OKAY;
      case (i_s_axi_araddr)
        ADDR_CTRL: n.rdata = {16'h0000, q.ctrl};
        ADDR_LEN:  n.rdata = {8'h00, q.len};
        ADDR_STAT: n.rdata = {17'h00000, q.di_seen, q.c_cnt, q.cap_lost,
                              q.rb_busy, q.err, q.gsr, q.oe, q.done_rel, q.st};
        default: begin
          n.rdata = 32'h0000_0000;
          n.rresp = RESP_SLVERR;
        end
      endcase
    end
    // Bitstream loading, one bit per cclk tick.
    if (q.st == ST_LOAD && q.tick) begin
      n.bit_cnt = q.bit_cnt + 24'h000001;
      n.fpos    = frame_end ? 8'h00 : q.fpos + 8'h01;
      if (q.fpos < 8'(FRAME_DATA_BITS)) begin
        // Running CRC is never reset between frames.
        n.crc = {q.crc[14:0], 1'b0} ^ ((q.crc[15] ^ q.s2[SI_DIN]) ? CRC_POLY : 16'h0000);
      end else begin
        n.chk = chk_got;
      end
      if (frame_end && (chk_got != chk_want)) begin
        n.st  = ST_ERR;
        n.err = 1'b1;
      end else if (q.bit_cnt + 24'h000001 == q.len) begin
        n.st = ST_STUP;
      end
    end
    // Startup sequencer.
    if (q.st == ST_STUP) begin
      if (q.tick && q.c_cnt != 3'h7) begin
        n.c_cnt = q.c_cnt + 3'h1;
      end
      if (ctl_user && sclk_edge && q.c_cnt != 3'h0 && q.u_cnt != 3'h7) begin
        n.u_cnt = q.u_cnt + 3'h1;
      end
      if (ctl_sync && q.s2[SI_DONE]) begin
        n.di_seen = 1'b1;
      end
      if (q.di_seen && sclk_edge && q.di_cnt != 2'h3) begin
        n.di_cnt = q.di_cnt + 2'h1;
      end
      n.done_rel = q.done_rel | ev_hit(1'b1, q.ctrl[CB_DONE +: 2], ctl_user,
                     ctl_sync, q.c_cnt, q.u_cnt, q.di_seen, q.di_cnt);
      n.oe = q.oe | ev_hit(1'b0, q.ctrl[CB_OE +: 2], ctl_user,
               ctl_sync, q.c_cnt, q.u_cnt, q.di_seen, q.di_cnt);
      n.gsr = q.gsr & !ev_hit(1'b0, q.ctrl[CB_GSR +: 2], ctl_user,
                ctl_sync, q.c_cnt, q.u_cnt, q.di_seen, q.di_cnt);
      if (q.done_rel && q.oe && !q.gsr) begin
        n.st = ST_RUN;
      end
    end
    // Readback: a lost capture is sticky until the next start.
    if (fifo_in_valid && !fifo_in_ready) begin
      n.cap_lost = 1'b1;
    end
    if (fifo_out_valid && fifo_out_ready) begin
      n.rb_busy = 1'b1;
      n.rb_sh   = fifo_out_data;
      n.rb_n    = '0;
    end else if (q.rb_busy && rb_edge) begin
      n.rb_dout = q.rb_sh[31];
      n.rb_sh   = {q.rb_sh[30:0], 1'b0};
      n.rb_n    = q.rb_n + 5'h01;
      n.rb_busy = (q.rb_n != 5'h1F);
    end
    if (fifo_flush) begin
      n.rb_busy = 1'b0;
    end
  end
  // ==========================================================
  // State register.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      q      <= '0;
      q.st   <= ST_IDLE;
      q.ctrl <= CTRL_RST;
      q.len  <= LEN_RST;
      q.gsr  <= 1'b1;
    end else begin
      q <= n;
    end
  end
  // ==========================================================
  // Checks.
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  sequence s_slow_gap;
    !q.tick [*8];
  endsequence
  property p_slow_rate;
    q.tick && !q.ctrl[CB_FAST] |=> s_slow_gap;
  endproperty
  a_slow_rate: assert property (p_slow_rate) else $error("cclk too fast");
  property p_done_od;
    (q.st == ST_RUN) |-> !o_done_oe && !o_done_o;
  endproperty
  a_done_od: assert property (p_done_od) else $error("done pin held");
  property p_fixed_chk;
    (q.st == ST_LOAD) && q.tick && frame_end && !q.ctrl[CB_CRC]
      && (chk_got != FIXED_TRAILER) |=> (q.st == ST_ERR) && o_cfg_error;
  endproperty
  a_fixed_chk: assert property (p_fixed_chk) else $error("bad trailer kept");
  property p_crc_chk;
    (q.st == ST_LOAD) && q.tick && frame_end && q.ctrl[CB_CRC]
      && (chk_got != q.crc[3:0]) |=> (q.st == ST_ERR);
  endproperty
  a_crc_chk: assert property (p_crc_chk) else $error("crc miss kept");
  property p_lcm;
    $rose(q.st == ST_STUP) |-> $past(q.bit_cnt) + 24'h000001 == q.len;
  endproperty
  a_lcm: assert property (p_lcm) else $error("early startup");
  property p_sync_hold;
    (q.st == ST_STUP) && ctl_sync && !ctl_user && !q.di_seen
      && q.ctrl[CB_OE + 1] |-> !o_outputs_en;
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("outputs before done in");
  sequence s_c1_edge;
    (q.st == ST_STUP) && !ctl_user && !ctl_sync && q.tick && (q.c_cnt == 3'h0)
      && (q.ctrl[CB_DONE +: 2] == 2'h0);
  endsequence
  property p_done_c1;
    s_c1_edge |-> ##2 !o_done_oe;
  endproperty
  a_done_c1: assert property (p_done_c1) else $error("done late");
  property p_abort;
    q.rb_busy && trig_fall && q.ctrl[CB_ABRT] |=> !o_rb_busy;
  endproperty
  a_abort: assert property (p_abort) else $error("abort ignored");
  property p_capture;
    fifo_in_valid && fifo_in_ready |=> fifo_out_valid;
  endproperty
  a_capture: assert property (p_capture) else $error("capture lost");
endmodule

// ---- verif/csr_src.sv ----
/* Bitstream source and done wire beside the configuration block.
   Assumes the block takes one bit on each o_cclk pulse once loading. */
`timescale 1ns/100ps
module csr_src (
  input  wire logic        i_sys_clk,
  input  wire logic        i_cclk,
  input  wire logic        i_arm,
  input  wire logic        i_done_oe,
  input  wire logic        i_hold_low,
  input  wire logic [63:0] i_bits,
  output logic             o_din,
  output logic             o_done_pin
);
  int pos;
  // ========
  // Done wire: open drain with a pull-up, either party may hold it low.
  assign o_done_pin = !(i_done_oe || i_hold_low);
  // The stream restarts while disarmed and steps on once per tick.
  always_ff @(posedge i_sys_clk) begin
    if (!i_arm) pos <= 0;
    else if (i_cclk) pos <= pos + 1;
  end
  // Past the end the line toggles, so a stray extra sample sees no steady level.
  assign o_din = (pos < 64) ? i_bits[63 - pos] : pos[0];
endmodule

// ---- verif/config_startup_readback_ctrl_test.sv ----
/* Self-checking bench for the configuration tail, startup and readback block.
   Assumes csr_src supplies the bitstream and resolves the done wire. */
`timescale 1ns/100ps
module config_startup_readback_ctrl_test
  import csr_pkg::*;
  ;
  typedef struct packed {
    logic       crc;
    logic       bad;
    logic       hl;
    logic [5:0] sel;
    logic [4:0] st;
    int         d_oe;
    int         d_gs;
  } csr_row_t;
  csr_row_t    rows [5] = '{'{1'b0, 1'b0, 1'b0, 6'h24, 5'h08, 2, 3},
                            '{1'b1, 1'b0, 1'b1, 6'h03, 5'h08, -2, -2},
                            '{1'b1, 1'b0, 1'b0, 6'h19, 5'h08, 2, 1},
                            '{1'b0, 1'b1, 1'b0, 6'h24, 5'h10, 0, 0},
                            '{1'b1, 1'b1, 1'b0, 6'h24, 5'h10, 0, 0}};
  logic        clk, rst, awv, wv, brd, arv, rrd, uclk, trig, arm, hl;
  logic [3:0]  awa, ara;
  logic [31:0] wd, cap, rdat;
  logic [63:0] bits;
  logic        awr, wrd, bv, arr, rvl, cclk, din, dpin, doe, oe, gsr, err, rbd, rbb, dlo;
  logic        p_dn, p_oe, p_gs;
  logic [1:0]  br, rr;
  int          fails, n_compared, tk = 0, tk_d = 0, t_dn, t_oe, t_gs;

  csr_top uut (.i_sys_clk(clk), .i_rst(rst), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
    .i_s_axi_awaddr(awa), .i_s_axi_wvalid(wv), .o_s_axi_wready(wrd), .i_s_axi_wdata(wd),
    .i_s_axi_wstrb(4'hF), .o_s_axi_bvalid(bv), .i_s_axi_bready(brd), .o_s_axi_bresp(br),
    .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .i_s_axi_araddr(ara), .o_s_axi_rvalid(rvl),
    .i_s_axi_rready(rrd), .o_s_axi_rdata(rdat), .o_s_axi_rresp(rr), .o_cclk(cclk),
    .i_cfg_din(din), .i_done_pin(dpin), .o_done_o(dlo), .o_done_oe(doe), .i_user_clk(uclk),
    .i_rb_clk(uclk), .i_rb_trig(trig), .i_cap_state(cap), .o_outputs_en(oe), .o_gsr(gsr),
    .o_cfg_error(err), .o_rb_dout(rbd), .o_rb_busy(rbb));
  csr_src src (.i_sys_clk(clk), .i_cclk(cclk), .i_arm(arm), .i_done_oe(doe),
    .i_hold_low(hl), .i_bits(bits), .o_din(din), .o_done_pin(dpin));

  // ========
  // Clocks: the user clock is slower and offset in phase from the system clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    uclk = 1'b0;
    #130;
    forever #400 uclk = ~uclk;
  end
  // Note the ticks seen before the edge at which each startup output moved.
  // Counting one edge back keeps a tick right after the done wire rises from
  // landing on both sides of a difference.
  always @(posedge clk) begin
    if (cclk) tk <= tk + 1;
    tk_d <= tk;
    if (p_dn && !doe) t_dn <= tk_d;
    if (!p_oe && oe) t_oe <= tk_d;
    if (p_gs && !gsr) t_gs <= tk_d;
    p_dn <= doe;
    p_oe <= oe;
    p_gs <= gsr;
  end

  // ========
  // Reporting and bus tasks.
  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic hang();
    fails++;
    $display("MISMATCH wait expected response seen timeout");
    test_done();
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // A control write arms the source one edge after the word is taken, the edge
  // at which a start takes effect, so both sides step on the same ticks.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brd <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (!wv && !bv && a == ADDR_CTRL) arm <= 1'b1;
      if (wrd && wv) wv <= 1'b0;
      if (bv) break;
    end
    brd <= 1'b0;
    if (n == 50) hang();
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rrd <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rvl) break;
    end
    d = rdat;
    r = rr;
    rrd <= 1'b0;
    if (n == 50) hang();
  endtask
  task automatic rst_dut();
    @(posedge clk);
    rst <= 1'b1;
    arm <= 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
  endtask
  // Two frames, 40 bits; the length write must not leave the source armed.
  task automatic load(input logic [15:0] c);
    wr(ADDR_LEN, 32'h0000_0028);
    arm <= 1'b0;
    wr(ADDR_CTRL, {16'h0000, c | 16'h8000});
  endtask
  task automatic wait_st(output logic [31:0] s);
    logic [1:0] r;
    int n;
    for (n = 0; n < 300; n++) begin
      rd(ADDR_STAT, s, r);
      if (s[4:3] != 2'b00) break;
    end
    if (n == 300) hang();
  endtask
  // Frames: 16 data bits, then four check bits MSB first; bad flips the last one.
  function automatic logic [63:0] mk(input logic crc, input logic bad);
    logic [63:0] s;
    logic [15:0] c, d;
    int p;
    s = 64'h0;
    c = 16'h0000;
    p = 63;
    for (int f = 0; f < 2; f++) begin
      d = (f == 0) ? 16'hA5C3 : 16'h3C5A;
      for (int i = 15; i >= 0; i--) begin
        c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0000);
        s[p] = d[i];
        p--;
      end
      for (int i = 3; i >= 0; i--) begin
        s[p] = (crc ? c[i] : FIXED_TRAILER[i]) ^ (bad && f == 1 && i == 0);
        p--;
      end
    end
    return s;
  endfunction

  // ========
  // Main sequence.
  initial begin
    logic [31:0] d, w;
    logic [1:0]  r;
    int          n, k, ws;
    rst = 1'b1;
    {awv, wv, brd, arv, rrd, trig, arm, hl} = 8'h00;
    awa = 4'h0;
    ara = 4'h0;
    wd = 32'h0;
    cap = 32'h0;
    bits = 64'h0;
    fails = 0;
    n_compared = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_CTRL, d, r);
    chk("ctrl", d, 32'h0000_0240);
    rd(ADDR_STAT, d, r);
    chk("state", d[4:0], 5'h01);
    chk("outputs", {doe, oe, gsr, dlo}, 4'hA);
    rd(4'hC, d, r);
    chk("resp", r, RESP_SLVERR);
    foreach (rows[i]) begin
      rst_dut();
      hl <= rows[i].hl;
      bits <= mk(rows[i].crc, rows[i].bad);
      load({6'h00, rows[i].sel, 2'b00, rows[i].crc, 1'b0});
      wait_st(d);
      chk("state", d[4:0], rows[i].st);
      chk("error", err, rows[i].st[4]);
      if (rows[i].st[3]) begin
        chk("oe_step", 32'(t_oe - t_dn), 32'(rows[i].d_oe));
        chk("gsr_step", 32'(t_gs - t_dn), 32'(rows[i].d_gs));
        chk("outputs", {doe, oe, gsr}, 3'b010);
      end else chk("outputs", {doe, oe, gsr}, 3'b101);
    end
    // Synchronised startup: outputs wait for the wire, reset follows one tick on.
    rst_dut();
    hl <= 1'b1;
    bits <= mk(1'b0, 1'b0);
    load(16'h0388);
    for (n = 0; n < 2000 && doe !== 1'b0; n++) @(posedge clk);
    if (n == 2000) hang();
    repeat (50) @(posedge clk);
    chk("oe_held", oe, 32'h0);
    hl <= 1'b0;
    wait_st(d);
    chk("state", d[4:0], 5'h08);
    chk("di_step", 32'(t_gs - t_oe), 32'h1);
    // Readback on configuration ticks, one bit per tick after each shift.
    cap <= 32'hC3A5_0F96;
    wr(ADDR_CTRL, 32'h0000_2B88);
    trig <= 1'b1;
    for (n = 0; n < 100 && rbb !== 1'b1; n++) @(posedge clk);
    if (n == 100) hang();
    for (k = 0; k < 32; k++) begin
      for (n = 0; n < 100 && !(cclk && rbb); n++) @(posedge clk);
      if (n == 100) hang();
      @(posedge clk);
      w[31 - k] = rbd;
    end
    chk("rb_word", w, 32'hC3A5_0F96);
    // Seven quick captures: one shifts, four queue, the rest are lost.
    repeat (14) begin
      repeat (4) @(posedge clk);
      trig <= ~trig;
    end
    rd(ADDR_STAT, d, r);
    chk("cap_lost", d[10], 32'h1);
    ws = 0;
    for (n = 0, k = 0; n < 4000 && k < 20; n++) begin
      @(posedge clk);
      k = rbb ? 0 : k + 1;
      if (rbb && k == 0 && w[0] == 1'b0) ws++;
      w[0] = rbb;
    end
    chk("words", ws, 32'h5);
    // Abort on the falling trigger while shifting on the user clock.
    wr(ADDR_CTRL, 32'h0000_3F88);
    trig <= 1'b0;
    repeat (8) @(posedge clk);
    trig <= 1'b1;
    for (n = 0; n < 100 && rbb !== 1'b1; n++) @(posedge clk);
    repeat (40) @(posedge clk);
    chk("rb_busy", rbb, 32'h1);
    trig <= 1'b0;
    for (n = 0; n < 8 && rbb !== 1'b0; n++) @(posedge clk);
    chk("abort", rbb, 32'h0);
    // Fast rate: once the slow count has run out, every cycle is a tick.
    wr(ADDR_CTRL, 32'h0000_0001);
    repeat (12) @(posedge clk);
    k = 0;
    repeat (20) begin
      @(posedge clk);
      k += cclk;
    end
    chk("fast", k, 32'h14);
    test_done();
  end
endmodule
